// *** include/tcp_pkg.sv ***
package tcp_pkg;

    // ==========================================
    // Sizes
    localparam int NUM_UNITS = 8;
    localparam int CNT_W = 16;
    localparam int DEAD_W = 8;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // ==========================================
    // Register offsets: REG_* are word indices within a unit, OFS_* are byte addresses
    // Per unit: base = unit index * UNIT_STRIDE
    localparam logic [ADDR_W-1:0] UNIT_STRIDE = 12'h020;
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_PERIOD = 3'h1;
    localparam logic [2:0] REG_COMPARE = 3'h2;
    localparam logic [2:0] REG_DEAD = 3'h3;
    localparam logic [2:0] REG_CAPTURE = 3'h4;
    localparam logic [2:0] REG_COUNT = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h100;
    localparam logic [ADDR_W-1:0] OFS_MASK = 12'h104;

    // ==========================================
    // Control field positions
    localparam int CTRL_EN = 0;
    localparam int CTRL_RELOAD = 1;
    localparam int CTRL_QUAD = 2;
    localparam int CTRL_SAFE_TRUE = 3;
    localparam int CTRL_SAFE_COMPL = 4;
    localparam int CTRL_HALTED = 5;
    localparam int CTRL_W = 5;

    // Status layout: period match in [7:0], capture in [15:8]
    localparam int STAT_TC = 0;
    localparam int STAT_CAP = 8;
    localparam int STAT_W = 16;

    // ==========================================
    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h02;
    localparam logic [CNT_W-1:0] PERIOD_RST = 16'hffff;
    localparam logic [CNT_W-1:0] COMPARE_RST = 16'h0000;
    localparam logic [DEAD_W-1:0] DEAD_RST = 8'h00;
    localparam logic [STAT_W-1:0] STAT_RST = 16'h0000;

    // ==========================================
    // Carriers
    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [DATA_W-1:0] pwdata;
    } tcp_apb_req_t;

    typedef struct packed {
        logic [NUM_UNITS-1:0] capture;
        logic [NUM_UNITS-1:0] quad_a;
        logic [NUM_UNITS-1:0] quad_b;
        logic kill;
    } tcp_pins_t;

    localparam int PINS_W = 3 * NUM_UNITS + 1;

endpackage

// *** core/tcp_sync.sv ***
`timescale 1ns/1ps
module tcp_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // ==========================================
    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// *** core/tcp_unit.sv ***
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
//   Function
// - 16-bit counter, software-set period length
// - Capture event copies counter into capture register
// - Period match halts or reloads per option in counter mode; quadrature mode always wraps
// - Compare values drive PWM duty outputs
// - True and complement outputs with dead band
// - Kill input forces outputs to safe state
// - Each unit offers quadrature decoding
// - Eight independent timer/counter/PWM units
module tcp_unit (
    input wire logic clk,
    input wire logic sys_rst,
    input wire tcp_pkg::tcp_apb_req_t apb_req,
    output logic [tcp_pkg::DATA_W-1:0] prdata_q,
    output logic pready_q,
    output logic pslverr_q,
    input wire tcp_pkg::tcp_pins_t pins_in,
    output logic [tcp_pkg::NUM_UNITS-1:0] line_q,
    output logic [tcp_pkg::NUM_UNITS-1:0] line_compl_q,
    output logic irq_q
);
    import tcp_pkg::*;

    // ==========================================
    // Input synchronisation
    tcp_pins_t pins_s;
    logic [PINS_W-1:0] pins_s_bits;

    tcp_sync #(
        .W(PINS_W)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(pins_in),
        .sync_out(pins_s_bits)
    );

    assign pins_s = pins_s_bits;

    // ==========================================
    // APB decode
    function automatic logic unit_hit(input logic [ADDR_W-1:0] a, input int u,
                                      input logic [2:0] r);
        logic [ADDR_W-1:0] base;
        base = ADDR_W'(u) * UNIT_STRIDE;
        unit_hit = (a == (base + {7'h00, r, 2'b00}));
    endfunction

    wire access = apb_req.psel & apb_req.penable;
    wire take = access & ~pready_q;
    wire wr_fire = access & pready_q & apb_req.pwrite;
    wire [ADDR_W-1:0] addr = apb_req.paddr;
    wire [DATA_W-1:0] wdata = apb_req.pwdata;
    wire unit_range = (addr < (ADDR_W'(NUM_UNITS) * UNIT_STRIDE));
    wire [2:0] reg_idx = addr[4:2];
    wire [2:0] unit_idx = addr[7:5];
    wire unit_valid = unit_range & (addr[1:0] == 2'b00) & (reg_idx <= REG_COUNT);
    wire hit_status = (addr == OFS_STATUS);
    wire hit_mask = (addr == OFS_MASK);
    wire mapped = unit_valid | hit_status | hit_mask;

    // ==========================================
    // Per-unit state gathered for readback
    logic [NUM_UNITS-1:0][CTRL_W-1:0] ctrl_all;
    logic [NUM_UNITS-1:0] halted_all;
    logic [NUM_UNITS-1:0][CNT_W-1:0] period_all;
    logic [NUM_UNITS-1:0][CNT_W-1:0] compare_all;
    logic [NUM_UNITS-1:0][DEAD_W-1:0] dead_all;
    logic [NUM_UNITS-1:0][CNT_W-1:0] capture_all;
    logic [NUM_UNITS-1:0][CNT_W-1:0] count_all;
    logic [NUM_UNITS-1:0] tc_evt;
    logic [NUM_UNITS-1:0] cap_evt;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
            logic [CTRL_W-1:0] ctrl_q;
            logic halted_q;
            logic [CNT_W-1:0] period_q;
            logic [CNT_W-1:0] compare_q;
            logic [DEAD_W-1:0] dead_cfg_q;
            logic [CNT_W-1:0] cap_q;
            logic [CNT_W-1:0] cnt_q;
            logic [CNT_W-1:0] cnt_d;
            logic halted_d;
            logic tc_d;
            logic cap_prev_q;
            logic qa_prev_q;
            logic qb_prev_q;
            logic raw_q;
            logic [DEAD_W-1:0] dead_cnt_q;

            wire wr_ctrl = wr_fire & unit_hit(addr, gi, REG_CTRL);
            wire en = ctrl_q[CTRL_EN];
            wire reload = ctrl_q[CTRL_RELOAD];
            wire quad = ctrl_q[CTRL_QUAD];
            wire at_period = (cnt_q == period_q);
            wire qa = pins_s.quad_a[gi];
            wire qb = pins_s.quad_b[gi];
            wire q_step = qa ^ qa_prev_q ^ qb ^ qb_prev_q;
            wire q_up = q_step & (qa ^ qb_prev_q);
            wire q_dn = q_step & (qb ^ qa_prev_q);
            wire cap_edge = pins_s.capture[gi] & ~cap_prev_q;
            wire raw = en & ~quad & (cnt_q < compare_q);
            wire dead_done = (dead_cnt_q == '0);

            // Counter next state
            always_comb begin
                cnt_d = cnt_q;
                halted_d = halted_q;
                tc_d = 1'b0;
                if (wr_ctrl) begin
                    cnt_d = '0;
                    halted_d = 1'b0;
                end else if (en && quad) begin
                    if (q_up) begin
                        tc_d = at_period;
                        cnt_d = at_period ? '0 : cnt_q + 1'b1;
                    end else if (q_dn) begin
                        tc_d = (cnt_q == '0);
                        cnt_d = (cnt_q == '0) ? period_q : cnt_q - 1'b1;
                    end
                end else if (en && !halted_q) begin
                    if (at_period) begin
                        tc_d = 1'b1;
                        if (reload) begin
                            cnt_d = '0;
                        end else begin
                            halted_d = 1'b1;
                        end
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
            end

            // Software registers
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    ctrl_q <= CTRL_RST;
                    period_q <= PERIOD_RST;
                    compare_q <= COMPARE_RST;
                    dead_cfg_q <= DEAD_RST;
                end else begin
                    if (wr_ctrl) begin
                        ctrl_q <= wdata[CTRL_W-1:0];
                    end
                    if (wr_fire && unit_hit(addr, gi, REG_PERIOD)) begin
                        period_q <= wdata[CNT_W-1:0];
                    end
                    if (wr_fire && unit_hit(addr, gi, REG_COMPARE)) begin
                        compare_q <= wdata[CNT_W-1:0];
                    end
                    if (wr_fire && unit_hit(addr, gi, REG_DEAD)) begin
                        dead_cfg_q <= wdata[DEAD_W-1:0];
                    end
                end
            end

            // Counter, capture and quadrature history
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    cnt_q <= '0;
                    halted_q <= 1'b0;
                    cap_q <= '0;
                    cap_prev_q <= 1'b0;
                    qa_prev_q <= 1'b0;
                    qb_prev_q <= 1'b0;
                end else begin
                    cnt_q <= cnt_d;
                    halted_q <= halted_d;
                    cap_prev_q <= pins_s.capture[gi];
                    qa_prev_q <= qa;
                    qb_prev_q <= qb;
                    if (en && cap_edge) begin
                        cap_q <= cnt_q;
                    end
                end
            end

            // Dead band: both outputs off for dead_cfg cycles after each edge
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    raw_q <= 1'b0;
                    dead_cnt_q <= '0;
                end else if (raw != raw_q) begin
                    raw_q <= raw;
                    dead_cnt_q <= dead_cfg_q;
                end else if (!dead_done) begin
                    dead_cnt_q <= dead_cnt_q - 1'b1;
                end
            end

            // Output stage; kill overrides for as long as it stays high
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    line_q[gi] <= 1'b0;
                    line_compl_q[gi] <= 1'b0;
                end else if (pins_s.kill) begin
                    line_q[gi] <= ctrl_q[CTRL_SAFE_TRUE];
                    line_compl_q[gi] <= ctrl_q[CTRL_SAFE_COMPL];
                end else if (!en || quad) begin
                    line_q[gi] <= 1'b0;
                    line_compl_q[gi] <= 1'b0;
                end else begin
                    line_q[gi] <= raw_q & dead_done;
                    line_compl_q[gi] <= ~raw_q & dead_done;
                end
            end

            assign ctrl_all[gi] = ctrl_q;
            assign halted_all[gi] = halted_q;
            assign period_all[gi] = period_q;
            assign compare_all[gi] = compare_q;
            assign dead_all[gi] = dead_cfg_q;
            assign capture_all[gi] = cap_q;
            assign count_all[gi] = cnt_q;
            assign tc_evt[gi] = tc_d;
            assign cap_evt[gi] = en & cap_edge;
        end
    endgenerate

    // ==========================================
    // Interrupt status and mask
    logic [STAT_W-1:0] status_q;
    logic [STAT_W-1:0] status_d;
    logic [STAT_W-1:0] mask_q;
    wire [STAT_W-1:0] events = {cap_evt, tc_evt};
    wire [STAT_W-1:0] clr_bits = (wr_fire & hit_status) ? wdata[STAT_W-1:0] : '0;

    // New event wins over a write-one-to-clear in the same cycle
    assign status_d = (status_q & ~clr_bits) | events;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_q <= STAT_RST;
            mask_q <= STAT_RST;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            if (wr_fire && hit_mask) begin
                mask_q <= wdata[STAT_W-1:0];
            end
            irq_q <= |(status_d & mask_q);
        end
    end

    // ==========================================
    // Read mux
    logic [DATA_W-1:0] rd_unit;
    logic [DATA_W-1:0] rd_data;

    always_comb begin
        rd_unit = '0;
        case (reg_idx)
            REG_CTRL: rd_unit = {26'h0000000, halted_all[unit_idx], ctrl_all[unit_idx]};
            REG_PERIOD: rd_unit = {16'h0000, period_all[unit_idx]};
            REG_COMPARE: rd_unit = {16'h0000, compare_all[unit_idx]};
            REG_DEAD: rd_unit = {24'h000000, dead_all[unit_idx]};
            REG_CAPTURE: rd_unit = {16'h0000, capture_all[unit_idx]};
            REG_COUNT: rd_unit = {16'h0000, count_all[unit_idx]};
            default: rd_unit = '0;
        endcase
    end

    assign rd_data = unit_valid ? rd_unit :
                     hit_status ? {16'h0000, status_q} :
                     hit_mask ? {16'h0000, mask_q} : '0;

    // ==========================================
    // APB answer: one wait state, then pready for one cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= take;
            pslverr_q <= take & ~mapped;
            if (take && !apb_req.pwrite) begin
                prdata_q <= rd_data;
            end
        end
    end
endmodule

// *** tb/tcp_unit_props.sv ***
`timescale 1ns/1ps
module tcp_unit_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire tcp_pkg::tcp_apb_req_t apb_req,
    input wire logic [tcp_pkg::DATA_W-1:0] prdata_q,
    input wire logic pready_q,
    input wire logic pslverr_q,
    input wire tcp_pkg::tcp_pins_t pins_in,
    input wire logic [tcp_pkg::NUM_UNITS-1:0] line_q,
    input wire logic [tcp_pkg::NUM_UNITS-1:0] line_compl_q,
    input wire logic irq_q
);
    import tcp_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // Register bus
    chk_apb_answer: assert property (
        apb_req.psel && !apb_req.penable |=> !pready_q ##1 pready_q)
        else $error("ready not after one wait state");
    chk_ready_access: assert property (
        pready_q |-> apb_req.psel && apb_req.penable)
        else $error("ready outside access phase");
    chk_ready_pulse: assert property (
        pready_q |=> !pready_q)
        else $error("ready longer than one cycle");
    chk_err_with_ready: assert property (
        pslverr_q |-> pready_q)
        else $error("error without ready");
    chk_err_read_zero: assert property (
        pready_q && pslverr_q && !apb_req.pwrite |-> prdata_q == '0)
        else $error("refused read data not zero");
    chk_irq_fall_write: assert property (
        $fell(irq_q) |-> $past(apb_req.psel && apb_req.penable && apb_req.pwrite && pready_q))
        else $error("interrupt dropped without a write");
    // ==========================================
    // Outputs
    chk_no_overlap: assert property (
        !pins_in.kill [*4] |-> (line_q & line_compl_q) == '0)
        else $error("true and complement high together");
    chk_kill_hold: assert property (
        pins_in.kill [*5] |-> $stable(line_q) && $stable(line_compl_q))
        else $error("outputs moved while killed");
endmodule
bind tcp_unit tcp_unit_props u_props (.clk(clk), .sys_rst(sys_rst), .apb_req(apb_req),
    .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q), .pins_in(pins_in),
    .line_q(line_q), .line_compl_q(line_compl_q), .irq_q(irq_q));

// *** tb/tcp_load.sv ***
`timescale 1ns/1ps
module tcp_load (
    input wire logic clk,
    input wire logic run,
    input wire logic [tcp_pkg::NUM_UNITS-1:0] line,
    input wire logic [tcp_pkg::NUM_UNITS-1:0] line_compl,
    output logic [15:0] on_cnt [tcp_pkg::NUM_UNITS],
    output logic [15:0] cmp_cnt [tcp_pkg::NUM_UNITS],
    output logic fault
);
    import tcp_pkg::*;
    // Switch pair on-time meters
    initial begin
        fault = 1'b0;
        for (int i = 0; i < NUM_UNITS; i++) begin
            on_cnt[i] = 16'h0000;
            cmp_cnt[i] = 16'h0000;
        end
    end
    always @(posedge clk) begin
        if ((line & line_compl) != '0) begin
            fault <= 1'b1;
        end
        for (int i = 0; i < NUM_UNITS; i++) begin
            if (run) begin
                on_cnt[i] <= on_cnt[i] + 16'(line[i]);
                cmp_cnt[i] <= cmp_cnt[i] + 16'(line_compl[i]);
            end
        end
    end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import tcp_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    tcp_apb_req_t req = '0;
    tcp_pins_t pins = '0;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, irq_q, run = 1'b0, fault, e;
    logic [7:0] line_q, line_compl_q;
    logic [15:0] on_cnt [NUM_UNITS];
    logic [15:0] cmp_cnt [NUM_UNITS];
    logic [31:0] r;
    int errors = 0;
    int check_count = 0;
    always #12.5 clk = ~clk;
    tcp_unit dut (.clk(clk), .sys_rst(sys_rst), .apb_req(req), .prdata_q(prdata_q),
        .pready_q(pready_q), .pslverr_q(pslverr_q), .pins_in(pins), .line_q(line_q),
        .line_compl_q(line_compl_q), .irq_q(irq_q));
    tcp_load u_load (.clk(clk), .run(run), .line(line_q), .line_compl(line_compl_q),
        .on_cnt(on_cnt), .cmp_cnt(cmp_cnt), .fault(fault));
    // ==========================================
    // Tasks
    task conclude;
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        req.paddr <= a;
        req.pwrite <= w;
        req.pwdata <= d;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready_q !== 1'b1);
        r = prdata_q;
        e = pslverr_q;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk);
        apb(a, 1'b0, 32'h0);
        chk(r & msk, exp);
        chk({31'h0, e}, 32'h0);
    endtask
    function automatic logic [11:0] ua(input int u, input logic [2:0] g);
        return 12'(u) * UNIT_STRIDE + {7'h00, g, 2'b00};
    endfunction
    task qstep(input logic a, input logic b);
        @(posedge clk);
        pins.quad_a[3] <= a;
        pins.quad_b[3] <= b;
        cyc(4);
    endtask
    // ==========================================
    // Tests
    initial begin
        cyc(5);
        sys_rst <= 1'b0;
        cyc(2);
        rd(ua(0, REG_CTRL), 32'h02, '1);
        rd(ua(0, REG_PERIOD), 32'hffff, '1);
        apb(12'h018, 1'b0, 32'h0);
        chk({r[31:1], e}, 32'h1);
        apb(ua(0, REG_PERIOD), 1'b1, 32'h9);
        apb(ua(0, REG_CTRL), 1'b1, 32'h1);
        cyc(20);
        rd(ua(0, REG_COUNT), 32'h9, '1);
        rd(ua(0, REG_CTRL), 32'h21, '1);
        @(posedge clk) pins.capture[0] <= 1'b1;
        cyc(2);
        pins.capture[0] <= 1'b0;
        cyc(4);
        rd(ua(0, REG_CAPTURE), 32'h9, '1);
        rd(OFS_STATUS, 32'h0101, 32'h0101);
        chk({31'h0, irq_q}, 32'h0);
        apb(OFS_MASK, 1'b1, 32'h0100);
        cyc(2);
        chk({31'h0, irq_q}, 32'h1);
        apb(OFS_STATUS, 1'b1, 32'h0101);
        cyc(2);
        chk({31'h0, irq_q}, 32'h0);
        rd(OFS_STATUS, 32'h0, 32'h0101);
        for (int u = 1; u < 3; u++) begin
            apb(ua(u, REG_PERIOD), 1'b1, 32'h9);
            apb(ua(u, REG_COMPARE), 1'b1, 32'h4);
            apb(ua(u, REG_DEAD), 1'b1, (u == 1) ? 32'h2 : 32'h0);
            apb(ua(u, REG_CTRL), 1'b1, (u == 1) ? 32'h0b : 32'h13);
        end
        cyc(30);
        run <= 1'b1;
        cyc(100);
        run <= 1'b0;
        @(posedge clk);
        chk({16'h0, on_cnt[1]}, 32'd20);
        chk({16'h0, cmp_cnt[1]}, 32'd40);
        chk({16'h0, on_cnt[2]}, 32'd40);
        chk({16'h0, cmp_cnt[2]}, 32'd60);
        chk({31'h0, fault}, 32'h0);
        pins.kill <= 1'b1;
        cyc(4);
        chk({line_q, line_compl_q}, 32'h0204);
        cyc(10);
        chk({line_q, line_compl_q}, 32'h0204);
        pins.kill <= 1'b0;
        apb(ua(3, REG_PERIOD), 1'b1, 32'h63);
        apb(ua(3, REG_CTRL), 1'b1, 32'h05);
        qstep(1, 0);
        qstep(1, 1);
        qstep(0, 1);
        qstep(0, 0);
        rd(ua(3, REG_COUNT), 32'h4, '1);
        chk({line_q[3], line_compl_q[3]}, 32'h0);
        qstep(0, 1);
        qstep(1, 1);
        qstep(1, 0);
        qstep(0, 0);
        qstep(0, 1);
        rd(ua(3, REG_COUNT), 32'h63, '1);
        rd(OFS_STATUS, 32'h0008, 32'h0008);
        conclude();
    end
    initial begin
        #100000;
        errors++;
        conclude();
    end
endmodule
